// ===== rtl/repeater_pkg.sv
/*
 * Repeater constants and types.
 * Assumes 50 MHz clock; low = dominant.
 */
package repeater_pkg;

    // ------------------------------------------------------------
    // clock and tick
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 50;
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_US       = 1;
    localparam int TICK_DIV      = TICK_US * CLK_MHZ;

    // ------------------------------------------------------------
    // dominant time-out
    // ------------------------------------------------------------
    localparam int DOM_TIMEOUT_MS = 25;
    localparam int DOM_MIN_MS     = 15;
    localparam int DOM_MAX_MS     = 45;
    localparam int TIMEOUT_TICKS  = DOM_TIMEOUT_MS * 1000 / TICK_US;
    localparam int MIN_TICKS      = DOM_MIN_MS * 1000 / TICK_US;
    localparam int MAX_TICKS      = DOM_MAX_MS * 1000 / TICK_US;

    // ------------------------------------------------------------
    // feedback suppression release
    // ------------------------------------------------------------
    localparam int BUS_ON_RX_NS   = 115;
    localparam int FBS_MIN_NS     = 5 + BUS_ON_RX_NS;
    localparam int FBS_MAX_NS     = 300;
    localparam int FBS_RELEASE_NS = 200;
    localparam int FBS_CYCLES     =
        (FBS_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FBS_MIN_CYCLES =
        (FBS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FBS_MAX_CYCLES = FBS_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // pins and trace
    // ------------------------------------------------------------
    localparam int PIN_W = 8;
    typedef struct packed {
        logic localTxN;
        logic expTxN;
        logic bus1Dis;
        logic bus2Dis;
        logic bus1CmpN;
        logic bus2CmpN;
        logic overTemp;
        logic belowPor;
    } pins_t;
    localparam logic [PIN_W-1:0] PIN_RESET = 8'hFD;

    localparam int TRACE_W     = 8;
    localparam int TRACE_DEPTH = 8;
    typedef struct packed {
        logic bus1Drv;
        logic bus2Drv;
        logic localRxN;
        logic expRxN;
        logic overTemp;
        logic bus1Mask;
        logic bus2Mask;
        logic anyTimeout;
    } trace_t;

    typedef enum logic [1:0] {
        FBS_IDLE  = 2'b00,
        FBS_DRIVE = 2'b01,
        FBS_HOLD  = 2'b10
    } fbs_state_t;

endpackage : repeater_pkg

// ===== rtl/dom_timer.sv
/*
 * Dominant time-out: recessive after LIMIT ticks.
 * Assumes a one-cycle tick.
 */
`timescale 1ns/1ps
module dom_timer #(
    parameter int LIMIT = 25000
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // control
    input  wire logic clear,
    input  wire logic tick,
    // level in and out, high = dominant
    input  wire logic domIn,
    output logic      domOut
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    logic [CW-1:0] cnt_q;
    logic          expired;

    if (LIMIT < 1) begin : g_chk
        $error("dom_timer: LIMIT must be positive");
    end

    assign expired = (cnt_q == LIM);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clear || !domIn) begin
            cnt_q <= '0;
        end else if (tick && !expired) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign domOut = domIn && !expired;

endmodule : dom_timer

// ===== rtl/sync_fifo.sv
/*
 * Single-clock valid/ready FIFO.
 * Assumes DEPTH a power of two.
 */
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // write side
    input  wire logic             wValid,
    output logic                  wReady,
    input  wire logic [WIDTH-1:0] wData,
    // read side
    output logic                  rValid,
    input  wire logic             rReady,
    output logic      [WIDTH-1:0] rData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wPtr_q;
    logic [AW-1:0]    rPtr_q;
    logic [AW:0]      count_q;
    logic             doWr;
    logic             doRd;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("sync_fifo: DEPTH must be a power of two >= 2");
    end

    assign wReady = (count_q != (AW+1)'(DEPTH));
    assign rValid = (count_q != '0);
    assign doWr   = wValid && wReady;
    assign doRd   = rValid && rReady;
    assign rData  = mem_q[rPtr_q];

    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            mem_q[wPtr_q] <= wData;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wPtr_q  <= '0;
            rPtr_q  <= '0;
            count_q <= '0;
        end else begin
            if (doWr) begin
                wPtr_q <= wPtr_q + AW'(1);
            end
            if (doRd) begin
                rPtr_q <= rPtr_q + AW'(1);
            end
            if (doWr && !doRd) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (doRd && !doWr) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end

endmodule : sync_fifo

// ===== rtl/dual_bus_repeater.sv
/*
 * Repeater logic of a dual-bus transceiver with a state trace.
 * Assumes pins async to ref_clk; analog side makes pin levels.
 */
`timescale 1ns/1ps

// Contract
// (R1) Open inputs read recessive.
// (R2) Low is dominant, high recessive.
// (R3) Received dominant drives enabled buses, rx low.
// (R4) Either tx low drives enabled buses.
// (R5) Local tx lowers both rx; expansion tx local rx only.
// (R6) Disabled bus stays recessive.
// (R7) Disabled receiver reads recessive, else comparator.
// (R8) Inputs timed; dominant over 25 ms forced recessive.
// (R9) Drivers on only for dominant.
// (R10) No priority between buses.
// (R11) Own driven bus receiver ignored.
// (R12) Reception masked a delay after driving.
// (R13) Below power-on: timers reset, inputs ignored, no tick.
// (R14) Below power-on: local rx high, outputs off, buses recessive.
// (R15) Over-temperature stops transmitters only.
// (R16) One bus fault spares the other.
// (R17) Release delay 5 ns plus bus-to-rx to 300 ns.
// (R18) Time-out 15 to 45 ms, 25 ms typical.
// (R19) Enabled buses act as one bus.
// (R20) Timers restart on recessive.
// (R21) Timers count ticks within allowed interval.
module dual_bus_repeater #(
    parameter int TIMEOUT_TICKS = repeater_pkg::TIMEOUT_TICKS,
    parameter int TICK_DIV      = repeater_pkg::TICK_DIV,
    parameter int FBS_CYCLES    = repeater_pkg::FBS_CYCLES,
    parameter int TRACE_DEPTH   = repeater_pkg::TRACE_DEPTH
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // controller and expansion inputs, low = dominant
    input  wire logic                 localTxIn,
    input  wire logic                 expTxIn,
    // bus disables, high = disabled
    input  wire logic                 bus1Disable,
    input  wire logic                 bus2Disable,
    // receive outputs with output enables
    output logic                      localRxOut,
    output logic                      localRxOe,
    output logic                      expRxOut,
    output logic                      expRxOe,
    // bus comparators, low = dominant
    input  wire logic                 bus1CmpIn,
    input  wire logic                 bus2CmpIn,
    // bus driver enables, high = driving dominant
    output logic                      bus1DrvOn,
    output logic                      bus2DrvOn,
    // supply and temperature monitors
    input  wire logic                 thermalShutdown,
    input  wire logic                 belowPor,
    // state trace stream
    output logic                      traceValid,
    input  wire logic                 traceReady,
    output repeater_pkg::trace_t      traceData
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // (R18) time-out inside allowed spread
    if (TIMEOUT_TICKS < repeater_pkg::MIN_TICKS ||
        TIMEOUT_TICKS > repeater_pkg::MAX_TICKS) begin : g_chkTo
        $error("time-out out of range");
    end
    // (R17) release delay bounds
    if (FBS_CYCLES < repeater_pkg::FBS_MIN_CYCLES ||
        FBS_CYCLES > repeater_pkg::FBS_MAX_CYCLES) begin : g_chkFbs
        $error("release delay out of range");
    end
    if (TICK_DIV < 2) begin : g_chkDiv
        $error("TICK_DIV below 2");
    end

    localparam int DW = $clog2(TICK_DIV);
    localparam int FW = $clog2(FBS_CYCLES + 1);
    localparam int PW = repeater_pkg::PIN_W;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    repeater_pkg::pins_t    pinRaw;
    repeater_pkg::pins_t    pinS;
    logic [PW-1:0]          meta_q;
    logic [PW-1:0]          sync_q;
    logic                   por;
    logic                   overTemp;
    logic [DW-1:0]          div_q;
    logic                   tick;
    logic [1:0]             busEn;
    logic [1:0]             rxGated;
    logic [1:0]             rxUnmasked;
    logic [1:0]             mask;
    logic [3:0]             timerIn;
    logic [3:0]             timed;
    logic                   txL;
    logic                   txE;
    logic [1:0]             rx;
    logic [1:0]             drvReq;
    logic [1:0]             drv_d;
    logic [1:0]             drv_q;
    logic                   localRx_d;
    logic                   expRx_d;
    logic                   localRx_q;
    logic                   expRx_q;
    logic                   expOe_q;
    logic                   anyTimeout;
    repeater_pkg::trace_t   traceNow;
    repeater_pkg::trace_t   traceLast_q;
    repeater_pkg::trace_t   pend_q;
    logic                   pending_q;
    logic                   pendReady;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    assign pinRaw = {localTxIn, expTxIn, bus1Disable, bus2Disable,
                     bus1CmpIn, bus2CmpIn, thermalShutdown, belowPor};

    for (genvar i = 0; i < PW; i++) begin : g_sync
        // (R1) recessive while unresolved
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= repeater_pkg::PIN_RESET[i];
                sync_q[i] <= repeater_pkg::PIN_RESET[i];
            end else begin
                meta_q[i] <= pinRaw[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign pinS     = repeater_pkg::pins_t'(sync_q);
    assign por      = pinS.belowPor;
    assign overTemp = pinS.overTemp;

    // ------------------------------------------------------------
    // oscillator tick divider
    // ------------------------------------------------------------
    // (R13) oscillator held stopped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (por || div_q == DW'(TICK_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    // (R21) time base for timers
    assign tick = !por && (div_q == DW'(TICK_DIV - 1));

    // ------------------------------------------------------------
    // receiver gating and feedback suppression
    // ------------------------------------------------------------
    // (R6) high disable pin level turns the bus off
    assign busEn = {!pinS.bus2Dis, !pinS.bus1Dis};

    // (R7) disabled receiver reads recessive
    assign rxGated = {busEn[1] && !pinS.bus2CmpN,
                      busEn[0] && !pinS.bus1CmpN};

    for (genvar b = 0; b < 2; b++) begin : g_fbs
        repeater_pkg::fbs_state_t state_q;
        logic [FW-1:0]            hold_q;

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                state_q <= repeater_pkg::FBS_IDLE;
                hold_q  <= '0;
            end else if (por) begin
                state_q <= repeater_pkg::FBS_IDLE;
                hold_q  <= '0;
            end else begin
                case (state_q)
                    repeater_pkg::FBS_IDLE: begin
                        // (R11) mask from first driven cycle
                        if (drv_q[b]) begin
                            state_q <= repeater_pkg::FBS_DRIVE;
                        end
                    end
                    repeater_pkg::FBS_DRIVE: begin
                        // (R12) start release delay
                        if (!drv_q[b]) begin
                            state_q <= repeater_pkg::FBS_HOLD;
                            hold_q  <= FW'(FBS_CYCLES - 1);
                        end
                    end
                    repeater_pkg::FBS_HOLD: begin
                        if (drv_q[b]) begin
                            state_q <= repeater_pkg::FBS_DRIVE;
                        end else if (hold_q == '0) begin
                            state_q <= repeater_pkg::FBS_IDLE;
                        end else begin
                            hold_q <= hold_q - FW'(1);
                        end
                    end
                    default: begin
                        state_q <= repeater_pkg::FBS_IDLE;
                    end
                endcase
            end
        end

        // registered drive: no loop through rx, echo is 2 syncs late
        assign mask[b] = (state_q != repeater_pkg::FBS_IDLE) || drv_q[b];
    end

    // (R11) own transmission not reflected
    assign rxUnmasked = rxGated & ~mask;

    // ------------------------------------------------------------
    // dominant time-out timers
    // ------------------------------------------------------------
    assign timerIn = {rxUnmasked[1], rxUnmasked[0],
                      !pinS.expTxN, !pinS.localTxN};

    for (genvar t = 0; t < 4; t++) begin : g_timer
        // (R8) independent timer per source
        // (R20) restart on recessive
        dom_timer #(
            .LIMIT  (TIMEOUT_TICKS)
        ) u_timer (
            .ref_clk(ref_clk),
            .rst_n  (rst_n),
            .clear  (por),
            .tick   (tick),
            .domIn  (timerIn[t]),
            .domOut (timed[t])
        );
    end

    // (R13) inputs ignored below threshold
    assign txL = timed[0] && !por;
    assign txE = timed[1] && !por;
    assign rx  = timed[3:2] & {2{!por}};

    assign anyTimeout = |(timerIn & ~timed);

    // ------------------------------------------------------------
    // repeater logic
    // ------------------------------------------------------------
    // (R4) transmit inputs drive enabled buses
    // (R3) received dominant repeated to other bus
    // (R10) symmetric cross terms
    // (R19) buses joined as one
    assign drvReq[0] = busEn[0] && (txL || txE || rx[1]);
    assign drvReq[1] = busEn[1] && (txL || txE || rx[0]);

    // (R6) disabled bus stays passive
    // (R15) thermal stop of drivers only
    // (R16) each bus gated on its own
    assign drv_d = drvReq & {2{!overTemp && !por}};

    // (R5) direct paths regardless of enables
    // (R3) receiver dominant on both outputs
    assign localRx_d = !(txL || txE || rx[0] || rx[1]);
    assign expRx_d   = !(txL || rx[0] || rx[1]);

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // (R9) drivers active only for dominant
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end

    // (R14) reset output states
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            localRx_q <= 1'b1;
            expRx_q   <= 1'b1;
            expOe_q   <= 1'b0;
        end else if (por) begin
            localRx_q <= 1'b1;
            expRx_q   <= 1'b1;
            expOe_q   <= 1'b0;
        end else begin
            localRx_q <= localRx_d;
            expRx_q   <= expRx_d;
            expOe_q   <= 1'b1;
        end
    end

    assign bus1DrvOn  = drv_q[0];
    assign bus2DrvOn  = drv_q[1];
    assign localRxOut = localRx_q;
    assign localRxOe  = 1'b1;
    assign expRxOut   = expRx_q;
    assign expRxOe    = expOe_q;

    // ------------------------------------------------------------
    // state trace capture
    // ------------------------------------------------------------
    assign traceNow = {
        drv_q[0],
        drv_q[1],
        localRx_q,
        expRx_q,
        overTemp,
        mask[0],
        mask[1],
        anyTimeout
    };

    // newest change, held while full
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            traceLast_q <= '0;
            pend_q      <= '0;
            pending_q   <= 1'b0;
        end else if (traceNow != traceLast_q) begin
            traceLast_q <= traceNow;
            pend_q      <= traceNow;
            pending_q   <= 1'b1;
        end else if (pendReady) begin
            pending_q   <= 1'b0;
        end
    end

    sync_fifo #(
        .WIDTH  (repeater_pkg::TRACE_W),
        .DEPTH  (TRACE_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n  (rst_n),
        .wValid (pending_q),
        .wReady (pendReady),
        .wData  (pend_q),
        .rValid (traceValid),
        .rReady (traceReady),
        .rData  (traceData)
    );

endmodule : dual_bus_repeater

// ===== verif/bus_node_model.sv
/*
 * Bus line model seen by one comparator.
 * Assumes level requests, high = dominant.
 */
`timescale 1ns/1ps
module bus_node_model #(
    parameter int LAG_NS = 0
) (
    // requests onto the bus, high = dominant
    input  wire logic drvOn,
    input  wire logic otherDom,
    // comparator result back to the device
    output logic      cmpN
);
    assign #(LAG_NS) cmpN = !(drvOn || otherDom);
endmodule : bus_node_model

// ===== verif/dual_bus_repeater_sva.sv
/*
 * Port checker of the repeater.
 * Sees only top pins; bound below.
 */
`timescale 1ns/1ps
module dual_bus_repeater_sva #(
    parameter int TIMEOUT_TICKS = 25000,
    parameter int TICK_DIV      = 50
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pins in, low = dominant
    input wire logic localTxIn,
    input wire logic expTxIn,
    input wire logic bus1Disable,
    input wire logic bus2Disable,
    input wire logic bus1CmpIn,
    input wire logic bus2CmpIn,
    input wire logic thermalShutdown,
    input wire logic belowPor,
    // pins out
    input wire logic localRxOut,
    input wire logic expRxOut,
    input wire logic expRxOe,
    input wire logic bus1DrvOn,
    input wire logic bus2DrvOn
);
    localparam int LATE  = TIMEOUT_TICKS * TICK_DIV + TICK_DIV + 6;
    localparam int EARLY = TIMEOUT_TICKS * TICK_DIV - 2 * TICK_DIV;
    int txLow;
    int quiet1;
    int quiet2;
    wire run  = !thermalShutdown && !belowPor;
    wire live = localTxIn && expTxIn && run && !bus1Disable && !bus2Disable;
    wire en1  = !bus1Disable && run;
    wire expOnly = localTxIn && bus1Disable && bus2Disable && !belowPor;
    wire hold = !localTxIn && expTxIn && bus1Disable && bus2Disable
                && !belowPor;
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txLow <= 0;
        end else begin
            txLow <= hold ? txLow + 1 : 0;
        end
    end
    // idle cycles per bus
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet1 <= 0;
            quiet2 <= 0;
        end else begin
            quiet1 <= (bus1DrvOn || bus1Disable || !run) ? 0 :
                      (quiet1 < 15 ? quiet1 + 1 : 15);
            quiet2 <= (bus2DrvOn || bus2Disable || !run) ? 0 :
                      (quiet2 < 15 ? quiet2 + 1 : 15);
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence txHeld(en);
        $fell(localTxIn) && en ##1 (!localTxIn && en)[*4];
    endsequence
    sequence busDom(cmp, quiet, own);
        $fell(cmp) && !own && live && quiet >= 12 ##1 (!cmp && live)[*4];
    endsequence
    property repeatTo(cmp, quiet, own, drv);
        busDom(cmp, quiet, own) |-> ##1 (drv && !localRxOut && !expRxOut);
    endproperty
    tx_to_bus_a: assert property (txHeld(en1) |-> ##1 bus1DrvOn)
        else $error("bus 1 not driven");
    tx_to_rx_a: assert property (txHeld(!belowPor) |-> ##1
        (!localRxOut && !expRxOut))
        else $error("rx outputs not low");
    exp_local_a: assert property ($fell(expTxIn) && expOnly ##1
        (!expTxIn && expOnly)[*4] |-> ##1 (expRxOut && !localRxOut))
        else $error("expansion path wrong");
    repeat_12_a: assert property (
        repeatTo(bus1CmpIn, quiet1, bus1DrvOn, bus2DrvOn))
        else $error("bus 1 not repeated");
    repeat_21_a: assert property (
        repeatTo(bus2CmpIn, quiet2, bus2DrvOn, bus1DrvOn))
        else $error("bus 2 not repeated");
    idle_passive_a: assert property (
        (localTxIn && expTxIn && bus1CmpIn && bus2CmpIn)[*5] |->
        (!bus1DrvOn && !bus2DrvOn && localRxOut && expRxOut))
        else $error("output active when idle");
    drive_gate_a: assert property (bus1Disable[*5] |-> !bus1DrvOn)
        else $error("disabled bus driven");
    thermal_off_a: assert property (thermalShutdown[*5] |->
        (!bus1DrvOn && !bus2DrvOn))
        else $error("driver on while hot");
    por_state_a: assert property (belowPor[*5] |-> (localRxOut
        && !expRxOe && !bus1DrvOn && !bus2DrvOn))
        else $error("power-on outputs wrong");
    timeout_late_a: assert property (txLow == LATE |-> localRxOut)
        else $error("time-out missed");
    timeout_early_a: assert property (txLow == EARLY |-> !localRxOut)
        else $error("time-out early");
endmodule : dual_bus_repeater_sva

bind dual_bus_repeater dual_bus_repeater_sva #(
    .TIMEOUT_TICKS(TIMEOUT_TICKS),
    .TICK_DIV(TICK_DIV)
) chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .localTxIn(localTxIn),
    .expTxIn(expTxIn), .bus1Disable(bus1Disable),
    .bus2Disable(bus2Disable), .bus1CmpIn(bus1CmpIn),
    .bus2CmpIn(bus2CmpIn), .thermalShutdown(thermalShutdown),
    .belowPor(belowPor), .localRxOut(localRxOut), .expRxOut(expRxOut),
    .expRxOe(expRxOe), .bus1DrvOn(bus1DrvOn), .bus2DrvOn(bus2DrvOn)
);

// ===== verif/test_dual_bus_repeater.sv
/*
 * Repeater bench: power-on, table, trace, random, time-out.
 * Assumes bound checker and two bus models.
 */
`timescale 1ns/1ps
module test_dual_bus_repeater;
    localparam int TDIV = 2;
    localparam int LIM  = repeater_pkg::TIMEOUT_TICKS * TDIV;
    logic ref_clk, rst_n, localTxIn, expTxIn, bus1Disable, bus2Disable;
    logic thermalShutdown, belowPor, traceReady, other1, other2;
    logic localRxOut, localRxOe, expRxOut, expRxOe, bus1DrvOn, bus2DrvOn;
    logic bus1CmpIn, bus2CmpIn, traceValid;
    repeater_pkg::trace_t traceData;
    repeater_pkg::trace_t lastWord;
    logic [6:0] v;
    int bad_count = 0;
    int checked   = 0;
    int cyc       = 0;
    int n;

    dual_bus_repeater #(.TICK_DIV(TDIV)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .localTxIn(localTxIn),
        .expTxIn(expTxIn), .bus1Disable(bus1Disable),
        .bus2Disable(bus2Disable), .localRxOut(localRxOut),
        .localRxOe(localRxOe), .expRxOut(expRxOut), .expRxOe(expRxOe),
        .bus1CmpIn(bus1CmpIn), .bus2CmpIn(bus2CmpIn),
        .bus1DrvOn(bus1DrvOn), .bus2DrvOn(bus2DrvOn),
        .thermalShutdown(thermalShutdown), .belowPor(belowPor),
        .traceValid(traceValid), .traceReady(traceReady),
        .traceData(traceData));
    bus_node_model node1 (.drvOn(bus1DrvOn), .otherDom(other1),
                          .cmpN(bus1CmpIn));
    bus_node_model #(.LAG_NS(30)) node2 (.drvOn(bus2DrvOn),
                          .otherDom(other2), .cmpN(bus2CmpIn));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            wrap_up();
        end
    end

    // pins {tx, exp, dis1, dis2, hot, other1, other2} -> drv1 drv2 rx erx
    function automatic logic [3:0] predict(logic [6:0] p);
        logic lt, et, d1, d2, th, o1, o2, txd, r1, r2;
        {lt, et, d1, d2, th, o1, o2} = p;
        txd = !lt || !et;
        r1 = !d1 && o1;
        r2 = !d2 && o2;
        return {!d1 && !th && (txd || r2), !d2 && !th && (txd || r1),
                !(txd || r1 || r2), !(!lt || r1 || r2)};
    endfunction : predict
    task automatic chk(string what, logic expv, logic got);
        checked++;
        if (got !== expv) begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", what, expv, got);
        end
    endtask : chk
    task automatic chkTrace(logic [4:0] expv, logic [4:0] got);
        checked++;
        if (got !== expv) begin
            bad_count++;
            $display("FAIL traceData expected %h seen %h", expv, got);
        end
    endtask : chkTrace
    task automatic apply(logic [6:0] pv, logic rdy);
        logic [3:0] pe;
        pe = predict(pv);
        @(posedge ref_clk);
        {localTxIn, expTxIn, bus1Disable, bus2Disable, thermalShutdown,
         other1, other2} <= pv;
        traceReady <= rdy;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("bus1DrvOn", pe[3], bus1DrvOn);
        chk("bus2DrvOn", pe[2], bus2DrvOn);
        chk("localRxOut", pe[1], localRxOut);
        chk("expRxOut", pe[0], expRxOut);
    endtask : apply
    task automatic wrap_up();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst_n = 1'b0;
        belowPor = 1'b1;
        traceReady = 1'b0;
        {localTxIn, expTxIn, bus1Disable, bus2Disable, thermalShutdown,
         other1, other2} = 7'h20;
        void'($urandom(69));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("localRxOut", 1'b1, localRxOut);
        chk("localRxOe", 1'b1, localRxOe);
        chk("expRxOe", 1'b0, expRxOe);
        chk("bus1DrvOn", 1'b0, bus1DrvOn);
        @(posedge ref_clk);
        belowPor <= 1'b0;
        apply(7'h20, 1'b0);
        chk("expRxOe", 1'b1, expRxOe);
        for (int i = 0; i < 16; i++) begin
            apply({i[1], i[0], i[3], i[2], 3'b000}, 1'b0);
        end
        chk("traceValid", 1'b1, traceValid);
        n = 0;
        @(posedge ref_clk);
        traceReady <= 1'b1;
        repeat (20) begin
            @(posedge ref_clk);
            if (traceValid === 1'b1 && traceReady === 1'b1) begin
                lastWord = traceData;
                n++;
            end
        end
        chk("traceValid", 1'b0, traceValid);
        chk("traceCount", 1'b1, n >= 8);
        chkTrace(5'h06, lastWord[7:3]);
        for (int k = 0; k < 40; k++) begin
            v = 7'($urandom);
            v[1:0] = (!v[6] || !v[5]) ? 2'b00 : v[1:0];
            v[0] = v[0] && !v[1];
            apply(v, 1'($urandom));
        end
        apply(7'h78, 1'b1);
        apply(7'h38, 1'b1);
        repeat (LIM - 2 * TDIV - 40) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("localRxOut", 1'b0, localRxOut);
        repeat (3 * TDIV + 40) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("localRxOut", 1'b1, localRxOut);
        chk("expRxOut", 1'b1, expRxOut);
        apply(7'h60, 1'b1);
        apply(7'h38, 1'b1);
        wrap_up();
    end
endmodule : test_dual_bus_repeater
